// ===== verilog/spcg_top.sv
// Port clock gating control with run, sleep and deep-sleep gate registers
//
// Functional notes
// - In Sleep, ports with their gate bit set keep their clock.
// - In Sleep, ports with their gate bit clear lose their clock.
// - Any access to an unclocked port is answered with a bus fault.
// - Sleep gate register resets to all zeros.
// - Gate bits: port E bit 4 down to port A bit 0.
// - Bits 31 to 5 read zero and ignore writes.
// - Run, sleep and deep-sleep registers apply in their own mode.
// - Sleep and deep-sleep registers apply only when auto gating is selected.
// - Sleep gate register sits at offset 0x118 from the control base.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module spcg_top (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  // Power mode from the processor
  input  wire spcg_pkg::spcg_mode_t          sys_mode,
  // Port clock enables
  output logic [spcg_pkg::SPCG_NPORT-1:0]    port_clk_en,
  // Port access check
  input  wire logic                          port_acc_req,
  input  wire logic [spcg_pkg::SPCG_PIDX_W-1:0] port_acc_sel,
  output logic                               port_acc_ok,
  output logic                               port_acc_fault,
  // Interrupt
  output logic                               irq
);
  import spcg_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  spcg_gate_if gif ();

  logic                  dp_valid_q;
  logic                  dp_write_q;
  logic [11:0]           dp_off_q;
  logic                  ap_take;
  logic                  ap_hit;
  logic                  wr_en;

  logic [SPCG_NPORT-1:0] run_gate_q;
  logic [SPCG_NPORT-1:0] run_gate_d;
  logic [SPCG_NPORT-1:0] sleep_gate_q;
  logic [SPCG_NPORT-1:0] sleep_gate_d;
  logic [SPCG_NPORT-1:0] deep_gate_q;
  logic [SPCG_NPORT-1:0] deep_gate_d;
  logic                  acg_q;
  logic                  acg_d;
  logic [SPCG_NPORT-1:0] int_st_q;
  logic [SPCG_NPORT-1:0] int_st_d;
  logic [SPCG_NPORT-1:0] int_en_q;
  logic [SPCG_NPORT-1:0] int_en_d;
  logic [SPCG_NPORT-1:0] int_clr;
  logic [SPCG_FCNT_W-1:0] fcnt_q;
  logic [SPCG_FCNT_W-1:0] fcnt_d;

  logic [SPCG_NPORT-1:0] port_clk_en_q;
  logic [31:0]           hrdata_q;
  logic [31:0]           rd_word;
  logic                  irq_q;
  logic                  fault_pulse;
  logic [SPCG_NPORT-1:0] fault_port;

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  // Only the upper 20 bits of the base are compared; bits 11:2 index the register
  assign ap_take = hsel && htrans[1] && hready;
  assign ap_hit  = (haddr[31:12] == SPCG_BASE[31:12]);

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_off_q   <= 12'h000;
    end else if (hready) begin
      dp_valid_q <= ap_take && ap_hit;
      dp_write_q <= hwrite;
      dp_off_q   <= {haddr[11:2], 2'h0};
    end
  end

  // Writes land in the data phase
  assign wr_en = dp_valid_q && dp_write_q;

  // ----------------------------------------------------------------
  // Gate registers
  // ----------------------------------------------------------------
  always_comb begin
    run_gate_d   = run_gate_q;
    sleep_gate_d = sleep_gate_q;
    deep_gate_d  = deep_gate_q;
    acg_d        = acg_q;
    int_en_d     = int_en_q;
    int_clr      = '0;
    if (wr_en) begin
      case (dp_off_q)
        SPCG_OFF_RUN_CFG: acg_d = hwdata[SPCG_ACG_BIT];
        SPCG_OFF_RUN:     run_gate_d = hwdata[SPCG_PORT_E_BIT:SPCG_PORT_A_BIT];
        // Upper bits are not stored, so writes to them vanish
        SPCG_OFF_SLEEP:   sleep_gate_d = hwdata[SPCG_PORT_E_BIT:SPCG_PORT_A_BIT];
        SPCG_OFF_DEEP:    deep_gate_d = hwdata[SPCG_PORT_E_BIT:SPCG_PORT_A_BIT];
        SPCG_OFF_INT_EN:  int_en_d = hwdata[SPCG_NPORT-1:0];
        SPCG_OFF_INT_CLR: int_clr = hwdata[SPCG_NPORT-1:0];
        default:          ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      run_gate_q   <= SPCG_GATE_RST;
      sleep_gate_q <= SPCG_GATE_RST;
      deep_gate_q  <= SPCG_GATE_RST;
      acg_q        <= 1'b0;
    end else begin
      run_gate_q   <= run_gate_d;
      sleep_gate_q <= sleep_gate_d;
      deep_gate_q  <= deep_gate_d;
      acg_q        <= acg_d;
    end
  end

  // ----------------------------------------------------------------
  // Mode selection and clock enables
  // ----------------------------------------------------------------
  assign gif.run_gate   = run_gate_q;
  assign gif.sleep_gate = sleep_gate_q;
  assign gif.deep_gate  = deep_gate_q;
  assign gif.auto_clock_gating_select        = acg_q;
  assign gif.mode       = sys_mode;

  spcg_gate_sel u_sel (
    .gif (gif.sel)
  );

  // Registered so the enable reaching the port cells is glitch free
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port_clk_en_q <= SPCG_GATE_RST;
    end else begin
      port_clk_en_q <= gif.active_gate;
    end
  end

  assign port_clk_en = port_clk_en_q;

  // ----------------------------------------------------------------
  // Port access check
  // ----------------------------------------------------------------
  spcg_fault_chk u_chk (
    .clk          (mclk),
    .rst_sync_n   (rst_sync_n),
    .acc_req      (port_acc_req),
    .acc_port     (port_acc_sel),
    .gif          (gif.chk),
    .acc_ok_q     (port_acc_ok),
    .acc_fault_q  (fault_pulse),
    .fault_port_q (fault_port)
  );

  assign port_acc_fault = fault_pulse;

  // ----------------------------------------------------------------
  // Interrupt status, enable and fault count
  // ----------------------------------------------------------------
  // A fault in the clearing cycle stays set
  assign int_st_d = (int_st_q & ~int_clr) | fault_port;

  always_comb begin
    fcnt_d = fcnt_q;
    if (fault_pulse && (fcnt_q != SPCG_FCNT_MAX)) begin
      fcnt_d = fcnt_q + SPCG_FCNT_W'(1);
    end
    if (wr_en && (dp_off_q == SPCG_OFF_FCNT)) begin
      fcnt_d = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      int_st_q <= '0;
      int_en_q <= '0;
      fcnt_q   <= '0;
      irq_q    <= 1'b0;
    end else begin
      int_st_q <= int_st_d;
      int_en_q <= int_en_d;
      fcnt_q   <= fcnt_d;
      irq_q    <= |(int_st_d & int_en_d);
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Built from next values so a read right behind a write sees it
  always_comb begin
    rd_word = SPCG_WORD_ZERO;
    case ({haddr[11:2], 2'h0})
      SPCG_OFF_RUN_CFG: rd_word[SPCG_ACG_BIT] = acg_d;
      SPCG_OFF_RUN:     rd_word[SPCG_NPORT-1:0] = run_gate_d;
      SPCG_OFF_SLEEP:   rd_word[SPCG_NPORT-1:0] = sleep_gate_d;
      SPCG_OFF_DEEP:    rd_word[SPCG_NPORT-1:0] = deep_gate_d;
      SPCG_OFF_INT_ST:  rd_word[SPCG_NPORT-1:0] = int_st_d;
      SPCG_OFF_INT_EN:  rd_word[SPCG_NPORT-1:0] = int_en_d;
      SPCG_OFF_GATE_ST: begin
        rd_word[SPCG_NPORT-1:0] = gif.active_gate;
        rd_word[SPCG_GST_MODE_LO+1:SPCG_GST_MODE_LO] = sys_mode;
      end
      SPCG_OFF_FCNT:    rd_word[SPCG_FCNT_W-1:0] = fcnt_d;
      default:          rd_word = SPCG_WORD_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hrdata_q <= SPCG_WORD_ZERO;
    end else if (ap_take && ap_hit && !hwrite) begin
      hrdata_q <= rd_word;
    end else if (hready) begin
      hrdata_q <= SPCG_WORD_ZERO;
    end
  end

  // Zero wait states, always OKAY
  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = SPCG_HRESP_OKAY;

endmodule

// ===== verilog/spcg_pkg.sv
// Constants and types for the sleep-mode port clock gating block
package spcg_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          SPCG_NPORT       = 5;
  localparam int          SPCG_PIDX_W      = 3;
  localparam int          SPCG_FCNT_W      = 8;

  // ----------------------------------------------------------------
  // Address map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] SPCG_BASE        = 32'h400F_E000;
  localparam logic [11:0] SPCG_OFF_RUN_CFG = 12'h060;
  localparam logic [11:0] SPCG_OFF_RUN     = 12'h108;
  localparam logic [11:0] SPCG_OFF_SLEEP   = 12'h118;
  localparam logic [11:0] SPCG_OFF_DEEP    = 12'h128;
  localparam logic [11:0] SPCG_OFF_INT_ST  = 12'h200;
  localparam logic [11:0] SPCG_OFF_INT_EN  = 12'h204;
  localparam logic [11:0] SPCG_OFF_INT_CLR = 12'h208;
  localparam logic [11:0] SPCG_OFF_GATE_ST = 12'h20C;
  localparam logic [11:0] SPCG_OFF_FCNT    = 12'h210;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          SPCG_PORT_A_BIT  = 0;
  localparam int          SPCG_PORT_E_BIT  = 4;
  localparam int          SPCG_ACG_BIT     = 27;
  localparam int          SPCG_GST_MODE_LO = 8;
  localparam logic [4:0]  SPCG_GATE_RST    = 5'h00;
  localparam logic [31:0] SPCG_WORD_ZERO   = 32'h0000_0000;
  localparam logic [7:0]  SPCG_FCNT_MAX    = 8'hFF;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic        SPCG_HRESP_OKAY  = 1'b0;

  typedef enum logic [1:0] {SPCG_RUN, SPCG_SLEEP, SPCG_DEEP} spcg_mode_t;

endpackage

// ===== verilog/spcg_gate_if.sv
// Gate bundle passed between the top and its selector and fault checker
`timescale 1ns/1ps
interface spcg_gate_if;
  import spcg_pkg::*;
  logic [SPCG_NPORT-1:0] run_gate;
  logic [SPCG_NPORT-1:0] sleep_gate;
  logic [SPCG_NPORT-1:0] deep_gate;
  logic                  auto_clock_gating_select;
  spcg_mode_t            mode;
  logic [SPCG_NPORT-1:0] active_gate;

  modport sel (input run_gate, input sleep_gate, input deep_gate,
               input auto_clock_gating_select, input mode, output active_gate);
  modport chk (input active_gate);
  modport top (output run_gate, output sleep_gate, output deep_gate,
               output auto_clock_gating_select, output mode, input active_gate);
endinterface

// ===== verilog/spcg_gate_sel.sv
// Picks the gate register that applies in the current power mode
`timescale 1ns/1ps
module spcg_gate_sel (
  spcg_gate_if.sel gif
);
  import spcg_pkg::*;

  always_comb begin
    gif.active_gate = gif.run_gate;
    if (gif.auto_clock_gating_select) begin
      case (gif.mode)
        SPCG_RUN:   gif.active_gate = gif.run_gate;
        SPCG_SLEEP: gif.active_gate = gif.sleep_gate;
        SPCG_DEEP:  gif.active_gate = gif.deep_gate;
        default:    gif.active_gate = gif.run_gate;
      endcase
    end else begin
      gif.active_gate = gif.run_gate;
    end
  end

endmodule

// ===== verilog/spcg_fault_chk.sv
// Answers each port access with a completion or a bus fault
`timescale 1ns/1ps
module spcg_fault_chk (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_sync_n,
  // Access attempt
  input  wire logic                         acc_req,
  input  wire logic [spcg_pkg::SPCG_PIDX_W-1:0] acc_port,
  spcg_gate_if.chk                          gif,
  // Answer
  output logic                              acc_ok_q,
  output logic                              acc_fault_q,
  output logic [spcg_pkg::SPCG_NPORT-1:0]   fault_port_q
);
  import spcg_pkg::*;

  logic in_range;
  logic clocked;

  // Unknown port numbers fault too, so a bad decode never hangs the bus
  assign in_range = (acc_port < SPCG_PIDX_W'(SPCG_NPORT));
  assign clocked  = in_range && gif.active_gate[acc_port];

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      acc_ok_q     <= 1'b0;
      acc_fault_q  <= 1'b0;
      fault_port_q <= '0;
    end else begin
      acc_ok_q     <= acc_req && clocked;
      acc_fault_q  <= acc_req && !clocked;
      fault_port_q <= '0;
      if (acc_req && !clocked && in_range) begin
        fault_port_q[acc_port] <= 1'b1;
      end
    end
  end

endmodule

// ===== dv/spcg_top_asserts.sv
// Port-level assertions for the sleep-mode port clock gating block
`timescale 1ns/1ps
module spcg_top_asserts (
  // Clock and reset
  input wire logic                          mclk,
  input wire logic                          rst_n,
  // Bus
  input wire logic                          hsel,
  input wire logic [31:0]                   haddr,
  input wire logic [1:0]                    htrans,
  input wire logic                          hwrite,
  input wire logic                          hready,
  input wire logic [31:0]                   hrdata,
  // Mode, enables, access check, interrupt
  input wire spcg_pkg::spcg_mode_t          sys_mode,
  input wire logic [spcg_pkg::SPCG_NPORT-1:0] port_clk_en,
  input wire logic                          port_acc_req,
  input wire logic [spcg_pkg::SPCG_PIDX_W-1:0] port_acc_sel,
  input wire logic                          port_acc_ok,
  input wire logic                          port_acc_fault,
  input wire logic                          irq
);
  import spcg_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Data phase trackers
  // ----------------------------------------------------------------
  logic        wdp_q;
  logic        rdp_q;
  logic [31:0] ra_q;
  logic        taken;
  assign taken = hsel && htrans[1] && hready;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdp_q <= 1'b0;
      rdp_q <= 1'b0;
      ra_q  <= 32'h0000_0000;
    end else begin
      wdp_q <= taken && hwrite;
      rdp_q <= taken && !hwrite;
      ra_q  <= haddr;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Enables lag the applied gate by one edge, so skip just-changed cases
  sequence s_steady_req;
    port_acc_req && port_acc_sel < 3'h5 && $stable(sys_mode) && !$past(wdp_q);
  endsequence
  sequence s_fault;
    port_acc_fault && !port_acc_ok;
  endsequence

  a_fault_when_off: assert property (s_steady_req ##0 !port_clk_en[port_acc_sel] |=> s_fault)
    else $error("clock-stopped port access not faulted");
  a_ok_when_on: assert property (s_steady_req ##0 port_clk_en[port_acc_sel] |=> port_acc_ok && !port_acc_fault)
    else $error("clocked port access not completed");
  a_bad_index: assert property (port_acc_req && port_acc_sel > 3'h4 |=> s_fault)
    else $error("nonexistent port access not faulted");
  a_one_answer: assert property ((port_acc_ok || port_acc_fault) |-> $past(port_acc_req) && !(port_acc_ok && port_acc_fault))
    else $error("access answer without request or doubled");
  a_reset_vals: assert property (disable iff (1'b0) !rst_n |-> port_clk_en == '0 && !irq && hrdata == '0)
    else $error("outputs not cleared in reset");
  a_reserved_zero: assert property (rdp_q && ra_q == SPCG_BASE + {20'h0, SPCG_OFF_SLEEP} |-> hrdata[31:5] == '0)
    else $error("reserved gate bits read nonzero");
  a_idle_rdata: assert property (!rdp_q |-> hrdata == '0)
    else $error("read data outside a read data phase");
  a_clk_en_cause: assert property ($changed(port_clk_en) |-> $past(wdp_q, 2) || $past(sys_mode) != $past(sys_mode, 2))
    else $error("clock enables changed without cause");
endmodule

// ===== dv/sleep_port_clock_gating_test.sv
// Self-checking bench for the sleep-mode port clock gating block
`timescale 1ns/1ps
module sleep_port_clock_gating_test;
  import spcg_pkg::*;
  logic        mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, port_acc_sel;
  logic        port_acc_req, port_acc_ok, port_acc_fault;
  logic [4:0]  port_clk_en;
  spcg_mode_t  sys_mode;
  int          fails, compares, cyc;
  assign hready = hreadyout;

  spcg_top u_spcg_top (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .sys_mode, .port_clk_en, .port_acc_req,
    .port_acc_sel, .port_acc_ok, .port_acc_fault, .irq);

  always #50 mclk = ~mclk;
  // Tests need well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] off, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, SPCG_BASE + {20'h0, off}, d, x);
  endtask
  task automatic rdc(input logic [11:0] off, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, SPCG_BASE + {20'h0, off}, 32'h0, x);
    check(x, exp);
  endtask
  // Expected pair is {ok, fault}
  task automatic acc(input logic [2:0] p, input logic [1:0] exp);
    port_acc_req <= 1'b1;
    port_acc_sel <= p;
    @(posedge mclk);
    port_acc_req <= 1'b0;
    @(posedge mclk);
    check(32'({port_acc_ok, port_acc_fault}), 32'(exp));
  endtask
  task automatic mode_chk(input spcg_mode_t m, input logic [4:0] exp);
    sys_mode <= m;
    repeat (2) @(posedge mclk);
    check(32'(port_clk_en), 32'(exp));
  endtask
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge mclk);
    check(32'(irq), 32'(exp));
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] x;
    {mclk, rst_n, hsel, hwrite, htrans, haddr, hwdata, port_acc_req, port_acc_sel} = '0;
    hsize = 3'h2;
    sys_mode = SPCG_RUN;
    {fails, compares, cyc} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    check(32'(port_clk_en), 32'h0);
    rdc(SPCG_OFF_SLEEP, 32'h0);
    wr(SPCG_OFF_SLEEP, 32'hFFFF_FFFF);
    rdc(SPCG_OFF_SLEEP, 32'h1F);
    bus(1'b1, 32'h400F_F118, 32'h0, x);
    rdc(SPCG_OFF_SLEEP, 32'h1F);
    rdc(12'h11C, 32'h0);
    wr(SPCG_OFF_RUN_CFG, 32'h1 << SPCG_ACG_BIT);
    sys_mode <= SPCG_SLEEP;
    for (int i = 0; i < 5; i++) begin
      wr(SPCG_OFF_SLEEP, 32'h1 << i);
      mode_chk(SPCG_SLEEP, 5'(1 << i));
      for (int j = 0; j < 5; j++) acc(3'(j), (i == j) ? 2'b10 : 2'b01);
    end
    acc(3'h5, 2'b01);
    acc(3'h7, 2'b01);
    wr(SPCG_OFF_RUN, 32'h05);
    wr(SPCG_OFF_DEEP, 32'h0A);
    mode_chk(SPCG_RUN, 5'h05);
    mode_chk(SPCG_DEEP, 5'h0A);
    mode_chk(SPCG_SLEEP, 5'h10);
    wr(SPCG_OFF_RUN_CFG, 32'h0);
    mode_chk(SPCG_SLEEP, 5'h05);
    mode_chk(SPCG_DEEP, 5'h05);
    rdc(SPCG_OFF_GATE_ST, 32'h0000_0205);
    acc(3'h1, 2'b01);
    acc(3'h0, 2'b10);
    rdc(SPCG_OFF_FCNT, 32'd23);
    // Interrupt: raise, mask, unmask, clear
    wr(SPCG_OFF_INT_CLR, 32'h1F);
    rdc(SPCG_OFF_INT_ST, 32'h0);
    // Port B is unclocked under the run gate, so its access faults
    wr(SPCG_OFF_INT_EN, 32'h02);
    acc(3'h1, 2'b01);
    irq_chk(1'b1);
    rdc(SPCG_OFF_INT_ST, 32'h02);
    wr(SPCG_OFF_INT_EN, 32'h0);
    irq_chk(1'b0);
    wr(SPCG_OFF_INT_EN, 32'h02);
    irq_chk(1'b1);
    wr(SPCG_OFF_INT_CLR, 32'h02);
    irq_chk(1'b0);
    rdc(SPCG_OFF_INT_CLR, 32'h0);
    // Reset in mid-run clears the gate register again
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc(SPCG_OFF_SLEEP, 32'h0);
    finish_test();
  end
endmodule

bind spcg_top spcg_top_asserts u_spcg_top_asserts (.mclk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .sys_mode, .port_clk_en, .port_acc_req, .port_acc_sel,
  .port_acc_ok, .port_acc_fault, .irq);
